// File: pkg/usrx_defines.vh
// Register offsets, field positions, reset values and timing constants
`ifndef USRX_DEFINES_VH
`define USRX_DEFINES_VH
// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define USRX_IDX_IRQ_FLAGS      8'h0c
`define USRX_IDX_RX_STAT_CTRL   8'h18
`define USRX_IDX_TX_HOLDING     8'h19
`define USRX_IDX_RX_HOLDING     8'h1a
`define USRX_IDX_IRQ_ENABLES    8'h8c
`define USRX_IDX_TX_STAT_CTRL   8'h98
`define USRX_IDX_BAUD_DIVISOR   8'h99
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define USRX_RS_PORT_EN         7
`define USRX_RS_NINE_BIT        6
`define USRX_RS_SINGLE_RX       5
`define USRX_RS_CONT_RX         4
`define USRX_RS_ADDR_DET        3
`define USRX_RS_FRAME_ERR       2
`define USRX_RS_OVERRUN         1
`define USRX_RS_NINTH_BIT       0
`define USRX_IF_RX              5
`define USRX_IF_TX              4
`define USRX_TS_HIGH_BAUD       2
`define USRX_TS_SHIFT_EMPTY     1
// ----------------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------------
`define USRX_RST_RX_STAT_CTRL   8'h00
`define USRX_RST_TX_STAT_CTRL   8'h02
`define USRX_RST_BAUD_DIVISOR   8'h00
`define USRX_WMASK_RX_STAT_CTRL 8'hf8
`define USRX_WMASK_TX_STAT_CTRL 8'hed
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define USRX_CLK_MHZ            100
`define USRX_OSC_MHZ            4
`define USRX_OSC_DIV            (`USRX_CLK_MHZ / `USRX_OSC_MHZ)
`define USRX_SAMPLES_PER_BIT    16
`define USRX_BRG_PRESCALE_LOW   4
`define USRX_BRG_PRESCALE_HIGH  1
`define USRX_FIFO_DEPTH         2
`endif

// File: hdl/usrx_baud_gen.v
// Baud tick generator: oscillator enable and divisor counter
`timescale 1ns/1ps
`include "usrx_defines.vh"
module usrx_baud_gen #(
   parameter OSC_DIV = `USRX_OSC_DIV
) (
   input  wire       clk_i,
   input  wire       rst_n_i,
   input  wire [7:0] divisor_i,
   input  wire       high_baud_i,
   output reg        tick_o
);
   // -------------------------------------------------------------------------
   // Oscillator enable: system clock is faster than the documented oscillator
   // -------------------------------------------------------------------------
   reg  [7:0] osc_cnt_ff;
   reg  [7:0] div_cnt_ff;
   reg  [1:0] pre_cnt_ff;
   wire       osc_en  = (osc_cnt_ff == OSC_DIV[7:0] - 8'h01);
   wire [1:0] pre_max = high_baud_i ? 2'h0 : 2'h3;

   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         osc_cnt_ff <= 8'h00;
         div_cnt_ff <= 8'h00;
         pre_cnt_ff <= 2'h0;
         tick_o     <= 1'b0;
      end else begin
         tick_o     <= 1'b0;
         osc_cnt_ff <= osc_en ? 8'h00 : osc_cnt_ff + 8'h01;
         if (osc_en) begin
            // Low speed: sample tick = osc/(4*(N+1)), 16 per bit gives osc/(64*(N+1)); high speed: osc/(N+1) and osc/(16*(N+1))
            if (pre_cnt_ff >= pre_max) begin
               pre_cnt_ff <= 2'h0;
               if (div_cnt_ff >= divisor_i) begin
                  div_cnt_ff <= 8'h00;
                  tick_o     <= 1'b1;
               end else begin
                  div_cnt_ff <= div_cnt_ff + 8'h01;
               end
            end else begin
               pre_cnt_ff <= pre_cnt_ff + 2'h1;
            end
         end
      end
   end
endmodule

// File: hdl/usrx_rx_fifo.v
// Two-deep receive holding memory with registered read data
`timescale 1ns/1ps
module usrx_rx_fifo #(
   parameter WIDTH = 9
) (
   input  wire             clk_i,
   input  wire             rst_n_i,
   input  wire             flush_i,
   input  wire             push_i,
   input  wire [WIDTH-1:0] push_data_i,
   input  wire             pop_i,
   output reg  [WIDTH-1:0] head_o,
   output reg  [1:0]       count_o
);
   reg [WIDTH-1:0] tail_ff;

   always @(posedge clk_i) begin
      if (!rst_n_i || flush_i) begin
         head_o  <= {WIDTH{1'b0}};
         tail_ff <= {WIDTH{1'b0}};
         count_o <= 2'h0;
      end else begin
         case ({push_i, pop_i})
            2'b10: begin
               if (count_o == 2'h0) head_o <= push_data_i;
               else tail_ff <= push_data_i;
               count_o <= count_o + 2'h1;
            end
            2'b01: begin
               head_o  <= tail_ff;
               count_o <= count_o - 2'h1;
            end
            2'b11: begin
               if (count_o == 2'h1) head_o <= push_data_i;
               else begin
                  head_o  <= tail_ff;
                  tail_ff <= push_data_i;
               end
            end
            default: begin
               head_o <= head_o;
            end
         endcase
      end
   end
endmodule

// File: hdl/usrx_top.v
// Serial receiver with nine-bit reception, address detect and APB registers
//
// Functional notes
// - Nine-bit mode captures nine bits; ninth goes to the ninth-bit status field.
// - Address detect active only with its bit 3 and nine-bit mode both set.
// - Address detect: load buffer and raise flag only when ninth bit is one.
// - Address detect: ninth-bit-zero character not buffered, no interrupt.
// - Ignored character in shift register is lost when the next shifts in.
// - Address detect bit has no effect in eight-bit mode.
// - Without address detect every character with a high stop bit buffered unless full; ninth bit passed unchanged.
// - Characters accepted only while continuous-receive enable bit 4 is set.
// - Each accepted character sets receive flag; interrupt when its enable set.
// - Clearing continuous-receive enable clears pending receive errors.
// - Low-speed divisor 0 gives highest rate, 255 the lowest.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "usrx_defines.vh"
module usrx_top (
   input  wire        CORE_CLK_I,
   input  wire        RESET_N_I,
   input  wire        PSEL_I,
   input  wire        PENABLE_I,
   input  wire        PWRITE_I,
   input  wire [11:0] PADDR_I,
   input  wire [31:0] PWDATA_I,
   output wire [31:0] PRDATA_O,
   output wire        PREADY_O,
   output wire        PSLVERR_O,
   input  wire        RX_I,
   output wire        IRQ_O
);
   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   localparam ST_IDLE  = 2'd0;
   localparam ST_START = 2'd1;
   localparam ST_DATA  = 2'd2;
   localparam ST_STOP  = 2'd3;

   reg  [7:0]  rx_ctrl_ff;
   reg  [7:0]  tx_ctrl_ff;
   reg  [7:0]  baud_divisor_ff;
   reg  [7:0]  tx_holding_ff;
   reg  [7:0]  irq_flags_ff;
   reg  [7:0]  irq_enables_ff;
   reg         frame_err_ff;
   reg         overrun_ff;
   reg  [31:0] prdata_ff;
   reg         sync1_ff;
   reg         sync2_ff;
   reg  [1:0]  state_ff;
   reg  [3:0]  tick_cnt_ff;
   reg  [3:0]  bit_cnt_ff;
   reg  [8:0]  rx_shift_reg_ff;
   reg  [1:0]  nxt_state;
   reg  [31:0] nxt_prdata;
   wire        tick;
   wire [8:0]  fifo_head;
   wire [1:0]  fifo_count;
   wire        char_done;
   wire        accept;
   wire        push;
   wire        pop;
   wire        flush;

   // Decode used by both read and write paths
   function is_reg;
      input [11:0] addr;
      input [7:0]  idx;
      begin
         is_reg = (addr == {2'b00, idx, 2'b00});
      end
   endfunction

   wire wr_acc      = PSEL_I & PENABLE_I & PWRITE_I;
   wire rd_acc      = PSEL_I & PENABLE_I & ~PWRITE_I;
   wire nine_bit    = rx_ctrl_ff[`USRX_RS_NINE_BIT];
   wire addr_det_on = rx_ctrl_ff[`USRX_RS_ADDR_DET] & nine_bit;
   wire cont_rx     = rx_ctrl_ff[`USRX_RS_CONT_RX];
   wire port_en     = rx_ctrl_ff[`USRX_RS_PORT_EN];

   // -------------------------------------------------------------------------
   // Line input synchroniser
   // -------------------------------------------------------------------------
   always @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) begin
         sync1_ff <= 1'b1;
         sync2_ff <= 1'b1;
      end else begin
         sync1_ff <= RX_I;
         sync2_ff <= sync1_ff;
      end
   end

   usrx_baud_gen u_baud (
      .clk_i       (CORE_CLK_I),
      .rst_n_i     (RESET_N_I),
      .divisor_i   (baud_divisor_ff),
      .high_baud_i (tx_ctrl_ff[`USRX_TS_HIGH_BAUD]),
      .tick_o      (tick)
   );

   // -------------------------------------------------------------------------
   // Receive state machine, 16 samples per bit, mid-bit sampling
   // -------------------------------------------------------------------------
   wire mid_bit   = tick & (tick_cnt_ff == 4'h7);
   wire last_tick = tick & (tick_cnt_ff == 4'hf);
   wire [3:0] data_bits = nine_bit ? 4'h9 : 4'h8;
   wire rx_on = port_en & cont_rx;

   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (!sync2_ff) nxt_state = ST_START;
         end
         ST_START: begin
            if (mid_bit) nxt_state = sync2_ff ? ST_IDLE : ST_DATA;
         end
         ST_DATA: begin
            if (last_tick && bit_cnt_ff == data_bits) nxt_state = ST_STOP;
         end
         default: begin
            if (mid_bit) nxt_state = ST_IDLE;
         end
      endcase
      if (!rx_on) nxt_state = ST_IDLE;
   end

   always @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) begin
         state_ff        <= ST_IDLE;
         tick_cnt_ff     <= 4'h0;
         bit_cnt_ff      <= 4'h0;
         rx_shift_reg_ff <= 9'h000;
      end else begin
         state_ff <= nxt_state;
         if (state_ff == ST_IDLE) begin
            tick_cnt_ff <= 4'h0;
            bit_cnt_ff  <= 4'h0;
         end else if (tick) begin
            tick_cnt_ff <= tick_cnt_ff + 4'h1;
            if (state_ff == ST_START && mid_bit) tick_cnt_ff <= 4'h8;
            if (state_ff == ST_DATA && mid_bit) begin
               // New character overwrites any ignored one in the shift register
               rx_shift_reg_ff <= {sync2_ff, rx_shift_reg_ff[8:1]};
               bit_cnt_ff      <= bit_cnt_ff + 4'h1;
            end
         end
      end
   end

   // Eight-bit characters arrive right-justified one place high; realign
   wire [8:0] rx_char = nine_bit ? rx_shift_reg_ff : {1'b0, rx_shift_reg_ff[8:1]};
   assign char_done = (state_ff == ST_STOP) & mid_bit;
   // Address detect drops characters whose ninth bit is zero
   assign accept = ~addr_det_on | rx_char[8];
   assign push   = char_done & sync2_ff & accept & (fifo_count != 2'h2);
   assign pop    = rd_acc & is_reg(PADDR_I, `USRX_IDX_RX_HOLDING) & (fifo_count != 2'h0);
   assign flush  = ~port_en;

   usrx_rx_fifo #(
      .WIDTH (9)
   ) u_fifo (
      .clk_i       (CORE_CLK_I),
      .rst_n_i     (RESET_N_I),
      .flush_i     (flush),
      .push_i      (push),
      .push_data_i (rx_char),
      .pop_i       (pop),
      .head_o      (fifo_head),
      .count_o     (fifo_count)
   );

   // -------------------------------------------------------------------------
   // Error flags
   // -------------------------------------------------------------------------
   wire cont_clear = wr_acc & is_reg(PADDR_I, `USRX_IDX_RX_STAT_CTRL)
                     & cont_rx & ~PWDATA_I[`USRX_RS_CONT_RX];

   always @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) begin
         frame_err_ff <= 1'b0;
         overrun_ff   <= 1'b0;
      end else begin
         if (char_done) frame_err_ff <= ~sync2_ff;
         // Set wins over the clear from the enable bit
         if (char_done & sync2_ff & accept & (fifo_count == 2'h2)) overrun_ff <= 1'b1;
         else if (cont_clear) overrun_ff <= 1'b0;
         if (cont_clear & ~char_done) frame_err_ff <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Register writes and interrupt flags
   // -------------------------------------------------------------------------
   always @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) begin
         rx_ctrl_ff      <= `USRX_RST_RX_STAT_CTRL;
         tx_ctrl_ff      <= `USRX_RST_TX_STAT_CTRL;
         baud_divisor_ff <= `USRX_RST_BAUD_DIVISOR;
         tx_holding_ff   <= 8'h00;
         irq_flags_ff    <= 8'h00;
         irq_enables_ff  <= 8'h00;
      end else begin
         if (wr_acc) begin
            if (is_reg(PADDR_I, `USRX_IDX_RX_STAT_CTRL))
               rx_ctrl_ff <= PWDATA_I[7:0] & `USRX_WMASK_RX_STAT_CTRL;
            else if (is_reg(PADDR_I, `USRX_IDX_TX_STAT_CTRL))
               tx_ctrl_ff <= (PWDATA_I[7:0] & `USRX_WMASK_TX_STAT_CTRL)
                             | 8'h02;
            else if (is_reg(PADDR_I, `USRX_IDX_BAUD_DIVISOR))
               baud_divisor_ff <= PWDATA_I[7:0];
            else if (is_reg(PADDR_I, `USRX_IDX_TX_HOLDING))
               tx_holding_ff <= PWDATA_I[7:0];
            else if (is_reg(PADDR_I, `USRX_IDX_IRQ_ENABLES))
               irq_enables_ff <= PWDATA_I[7:0] & 8'hf7;
            else if (is_reg(PADDR_I, `USRX_IDX_IRQ_FLAGS))
               irq_flags_ff <= irq_flags_ff & ~(PWDATA_I[7:0] & 8'hdf);
         end
         // Receive flag set on arrival, cleared by the last read or a write of one; an arriving character wins
         if (push)
            irq_flags_ff[`USRX_IF_RX] <= 1'b1;
         else if (pop && fifo_count == 2'h1)
            irq_flags_ff[`USRX_IF_RX] <= 1'b0;
         else if (wr_acc && is_reg(PADDR_I, `USRX_IDX_IRQ_FLAGS)
                  && PWDATA_I[`USRX_IF_RX])
            irq_flags_ff[`USRX_IF_RX] <= 1'b0;
      end
   end

   assign IRQ_O = |(irq_flags_ff & irq_enables_ff);

   // -------------------------------------------------------------------------
   // APB read path, zero wait states
   // -------------------------------------------------------------------------
   always @* begin
      nxt_prdata = 32'h0000_0000;
      if (is_reg(PADDR_I, `USRX_IDX_RX_STAT_CTRL))
         nxt_prdata[7:0] = {rx_ctrl_ff[7:3], frame_err_ff, overrun_ff,
                            fifo_head[8]};
      else if (is_reg(PADDR_I, `USRX_IDX_RX_HOLDING))
         nxt_prdata[7:0] = fifo_head[7:0];
      else if (is_reg(PADDR_I, `USRX_IDX_IRQ_FLAGS))
         nxt_prdata[7:0] = irq_flags_ff;
      else if (is_reg(PADDR_I, `USRX_IDX_IRQ_ENABLES))
         nxt_prdata[7:0] = irq_enables_ff;
      else if (is_reg(PADDR_I, `USRX_IDX_TX_STAT_CTRL))
         nxt_prdata[7:0] = tx_ctrl_ff;
      else if (is_reg(PADDR_I, `USRX_IDX_BAUD_DIVISOR))
         nxt_prdata[7:0] = baud_divisor_ff;
      else if (is_reg(PADDR_I, `USRX_IDX_TX_HOLDING))
         nxt_prdata[7:0] = tx_holding_ff;
   end

   // Read data captured in setup so it is registered in the access phase
   always @(posedge CORE_CLK_I) begin
      if (!RESET_N_I) prdata_ff <= 32'h0000_0000;
      else if (PSEL_I && !PENABLE_I) prdata_ff <= nxt_prdata;
   end

   wire mapped = is_reg(PADDR_I, `USRX_IDX_RX_STAT_CTRL) |
                 is_reg(PADDR_I, `USRX_IDX_RX_HOLDING) |
                 is_reg(PADDR_I, `USRX_IDX_IRQ_FLAGS) |
                 is_reg(PADDR_I, `USRX_IDX_IRQ_ENABLES) |
                 is_reg(PADDR_I, `USRX_IDX_TX_STAT_CTRL) |
                 is_reg(PADDR_I, `USRX_IDX_BAUD_DIVISOR) |
                 is_reg(PADDR_I, `USRX_IDX_TX_HOLDING);

   assign PRDATA_O  = prdata_ff;
   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
endmodule

// File: verification/usrx_top_asserts.sv
// Checker for bus and interrupt behaviour at the receiver's ports
`timescale 1ns/1ps
`include "usrx_defines.vh"
module usrx_top_asserts (
   input wire        CORE_CLK_I,
   input wire        RESET_N_I,
   input wire        PSEL_I,
   input wire        PENABLE_I,
   input wire        PWRITE_I,
   input wire [11:0] PADDR_I,
   input wire [31:0] PWDATA_I,
   input wire [31:0] PRDATA_O,
   input wire        PREADY_O,
   input wire        PSLVERR_O,
   input wire        RX_I,
   input wire        IRQ_O
);
   wire [9:0] idx = PADDR_I[11:2];
   wire       mapped = (PADDR_I[1:0] == 2'b00) && (idx == `USRX_IDX_IRQ_FLAGS
      || idx == `USRX_IDX_RX_STAT_CTRL || idx == `USRX_IDX_TX_HOLDING
      || idx == `USRX_IDX_RX_HOLDING || idx == `USRX_IDX_IRQ_ENABLES
      || idx == `USRX_IDX_TX_STAT_CTRL || idx == `USRX_IDX_BAUD_DIVISOR);
   // ------------------------------------------------------------
   // Bus and interrupt relations; line timing is judged by the bench
   // ------------------------------------------------------------
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   sequence s_acc; PSEL_I && PENABLE_I && PREADY_O; endsequence
   sequence s_wr(i); s_acc ##0 (PWRITE_I && idx == i); endsequence
   sequence s_rd_end; s_acc ##0 !PWRITE_I ##1 !PSEL_I; endsequence
   a_ready_no_wait: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
      else $error("access without ready");
   a_err_unmapped: assert property (s_acc |-> PSLVERR_O == !mapped)
      else $error("slave error does not match map");
   a_rd_unmapped_zero: assert property (s_acc ##0 (!PWRITE_I && !mapped) |-> PRDATA_O == 0)
      else $error("unmapped read not zero");
   a_rdata_upper_zero: assert property (s_acc ##0 !PWRITE_I |-> PRDATA_O[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_rdata_holds: assert property (s_rd_end |-> $stable(PRDATA_O))
      else $error("read data changed after access");
   a_irq_rise_cause: assert property ($rose(IRQ_O) |->
      $past(PSEL_I && PENABLE_I && PWRITE_I) || (RX_I && $past(RX_I, 8)))
      else $error("interrupt rose without a cause");
   a_irq_fall_cause: assert property ($fell(IRQ_O) |-> $past(PSEL_I && PENABLE_I))
      else $error("interrupt fell without an access");
   a_mask_drops_irq: assert property (s_wr(`USRX_IDX_IRQ_ENABLES) ##0 !PWDATA_I[5] |=> !IRQ_O)
      else $error("masked interrupt still high");
   a_w1c_drops_irq: assert property (s_wr(`USRX_IDX_IRQ_FLAGS) ##0 PWDATA_I[5] |=> !IRQ_O)
      else $error("cleared flag still interrupts");
endmodule
bind usrx_top usrx_top_asserts i_usrx_top_asserts (.CORE_CLK_I(CORE_CLK_I),
   .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
   .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
   .PSLVERR_O(PSLVERR_O), .RX_I(RX_I), .IRQ_O(IRQ_O));

// File: verification/usrx_line_master.sv
// Serial line master model sending characters to the receiver
`timescale 1ns/1ps
module usrx_line_master (
   input  wire  clk_i,
   output logic line_o
);
   // Idle line rests high, as a pulled-up mark state would
   initial line_o = 1'b1;
   task automatic send(input logic [8:0] d, input bit nine, input logic stop, input int bclk);
      logic [10:0] frame;
      int          n;
      frame = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
      n = nine ? 11 : 10;
      // LSB first; a low stop bit only when a bench case asks for one
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         line_o <= frame[i];
         repeat (bclk - 1) @(posedge clk_i);
      end
      @(posedge clk_i);
      line_o <= 1'b1;
   endtask
endmodule

// File: verification/usrx_top_tb.sv
// Self-checking bench for the nine-bit receiver with address detect
`timescale 1ns/1ps
`include "usrx_defines.vh"
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin fails++; \
   $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, x); end end
module usrx_top_tb;
   localparam logic [11:0] A_FLG = 12'h030, A_RXC = 12'h060, A_TXH = 12'h064;
   localparam logic [11:0] A_HLD = 12'h068, A_ENA = 12'h230, A_TXC = 12'h260, A_DIV = 12'h264;
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, r;
   logic [8:0]  v [2];
   logic [11:0] addrs [7] = '{A_FLG, A_RXC, A_TXH, A_HLD, A_ENA, A_TXC, A_DIV};
   logic [7:0]  rstv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
   wire  [31:0] prdata;
   wire         pready, pslverr, rx, irq;
   int          fails = 0, n_tests = 0, seed = 4, bclk;
   usrx_top i_usrx_top (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .RX_I(rx), .IRQ_O(irq));
   usrx_line_master i_usrx_line_master (.clk_i(clk), .line_o(rx));
   initial forever #5 clk = ~clk;
   function automatic int bit_clks(input int div, input bit high);
      return (high ? 16 : 64) * `USRX_OSC_DIV * (div + 1);
   endfunction
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Request held until ready is seen high; a stuck bus ends the run
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fails++;
         give_verdict();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 8'h00);
      `CHK(r & m, x)
   endtask
   task automatic send(input logic [8:0] d, input bit nine, input logic stop);
      i_usrx_line_master.send(d, nine, stop, bclk);
      repeat (20) @(posedge clk);
   endtask
   task automatic irq_is(input logic x);
      @(posedge clk);
      `CHK(irq, x)
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 7; i++) rchk(addrs[i], 32'hff, rstv[i]);
      apb(1'b0, 12'h3fc, 8'h00);
      `CHK({r, e}, 33'h1)
      // Setup order: divisor, speed, port, interrupt, nine-bit, detect, receive
      wr(A_DIV, 8'h00);
      wr(A_TXC, 8'h04);
      rchk(A_TXC, 32'hff, 32'h06);
      wr(A_RXC, 8'h80);
      wr(A_ENA, 8'h20);
      wr(A_RXC, 8'hc0);
      wr(A_RXC, 8'hc8);
      wr(A_RXC, 8'hd8);
      bclk = bit_clks(0, 1'b1);
      v[0] = $random(seed);
      v[1] = $random(seed);
      send({1'b0, v[0][7:0]}, 1'b1, 1'b1);
      rchk(A_FLG, 32'h20, 32'h00);
      send({1'b1, v[1][7:0]}, 1'b1, 1'b1);
      irq_is(1'b1);
      rchk(A_RXC, 32'h01, 32'h01);
      rchk(A_HLD, 32'hff, v[1][7:0]);
      irq_is(1'b0);
      wr(A_RXC, 8'hd0);
      for (int i = 0; i < 2; i++) begin
         v[i] = $random(seed);
         send(v[i], 1'b1, 1'b1);
      end
      for (int i = 0; i < 2; i++) begin
         irq_is(1'b1);
         rchk(A_RXC, 32'h01, v[i][8]);
         rchk(A_HLD, 32'hff, v[i][7:0]);
      end
      irq_is(1'b0);
      send(v[0], 1'b1, 1'b1);
      wr(A_ENA, 8'h00);
      irq_is(1'b0);
      rchk(A_FLG, 32'h20, 32'h20);
      wr(A_ENA, 8'h20);
      irq_is(1'b1);
      wr(A_FLG, 8'h20);
      irq_is(1'b0);
      rchk(A_HLD, 32'hff, v[0][7:0]);
      wr(A_RXC, 8'h98);
      send(v[1], 1'b0, 1'b1);
      rchk(A_HLD, 32'hff, v[1][7:0]);
      wr(A_RXC, 8'h80);
      send(v[0], 1'b0, 1'b1);
      rchk(A_FLG, 32'h20, 32'h00);
      // Slow rate last: a character takes four times longer here
      wr(A_TXC, 8'h00);
      wr(A_RXC, 8'h90);
      bclk = bit_clks(0, 1'b0);
      send(v[1], 1'b0, 1'b1);
      rchk(A_HLD, 32'hff, v[1][7:0]);
      send(v[0], 1'b0, 1'b0);
      rchk(A_RXC, 32'h04, 32'h04);
      wr(A_RXC, 8'h80);
      rchk(A_RXC, 32'h04, 32'h00);
      give_verdict();
   end
endmodule
